/* shared/fmc_pkg.sv */
// Constants, register map and carrier types of the frequency measure counter
package fmc_pkg;
	localparam int          NCH        = 8;                // Counters in the block
	localparam int          FIFO_AW    = 2;                // Buffer address width
	localparam int          FIFO_DEPTH = 4;                // Samples per counter buffer
	localparam int          ADDR_W     = 8;                // APB byte address width
	localparam int          CFG_W      = 13;               // Used bits of a config word

	// Per-counter block of four words at byte address counter*16
	localparam logic [3:0]  OFF_CFG    = 4'h0;             // Configuration word
	localparam logic [3:0]  OFF_DIV    = 4'h4;             // Divide-down count or gate time
	localparam logic [3:0]  OFF_PER    = 4'h8;             // Head sample, period count
	localparam logic [3:0]  OFF_TB     = 4'hC;             // Head sample, timebase count; read pops
	localparam logic [7:0]  OFF_STATUS = 8'h80;            // Buffer not-empty and overflow flags

	// Reset values
	localparam logic [31:0] DIV_RESET  = 32'h0000_0004;    // Default divide-down integer
	localparam logic [3:0]  TBSRC_INT  = 4'h0;             // Internal timebase selection, block clock at 20 MHz

	// Measurement methods
	localparam logic [1:0]  METH_SAMPLE  = 2'h0;           // Sample clock, with or without averaging
	localparam logic [1:0]  METH_LOWFREQ = 2'h1;           // One counter, one period
	localparam logic [1:0]  METH_LARGE   = 2'h2;           // Two counters, divided-down gate

	// Counter sequence
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,                                  // Disabled or occupied
		ST_ARM  = 3'b010,                                  // Waiting for first input edge
		ST_RUN  = 3'b100                                   // Measuring
	} fmc_state_t;

	// Configuration word, bit 0 at the right
	typedef struct packed {
		logic [3:0] timebase_source_select;                // 0 internal, 1..8 terminal 0..7
		logic [2:0] input_terminal_select;                 // Terminal carrying the input
		logic       enable;                                // Arm the counter
		logic       time_mode;                             // Large range gate by time, not periods
		logic       implicit_timing;                       // Low-frequency method without sample clock
		logic       averaging_enable;                      // Sample clock averaging
		logic [1:0] method_select;                         // Measurement method
	} fmc_cfg_t;

	// One buffered measurement
	typedef struct packed {
		logic [31:0] period_count;                         // Input periods measured
		logic [31:0] timebase_cycle_count;                 // Timebase cycles spanned
	} fmc_sample_t;
endpackage

/* hw/fmc_top.sv */
// Eight-counter frequency measurement block with APB registers
//
// What this block does
// - Averaging: count full periods between sample edges
// - Averaging: count timebase cycles over those periods
// - Averaging: buffer both counts per sample edge
// - Non-averaging: time last full period before edge
// - Non-averaging: buffer a period count of one and the single-period timebase count, or zeros before the first full period
// - Averaging enable picks between both sample methods
// - Low frequency: time one full input period per result
// - Low frequency: sample-clock or implicit timing
// - Large range: first counter gates N input periods
// - Large range: partner counts timebase during gate
// - Large range: return period and timebase counts
// - Large range divide-down integer is programmable
// - Pairs are fixed: 0-1, 2-3, 4-5, 6-7
// - Eight counters; pairs occupy two
// - Timebase resets to internal; selectable source
// - Input from selectable terminal, default per counter
// - One measurement per sample clock edge
// - Fixed-time implicit result after programmed time
// - Fixed-period implicit result after N periods
//
// Decided for this implementation: the register addresses and register access over APB.
`timescale 1ns/10ps
module fmc_top (
	input  wire logic                        MCLK,       // Block clock, 20 MHz
	input  wire logic                        RST,        // Asynchronous reset, active high
	input  wire logic                        PSEL,       // APB select
	input  wire logic                        PENABLE,    // APB access phase
	input  wire logic                        PWRITE,     // APB direction
	input  wire logic [fmc_pkg::ADDR_W-1:0]  PADDR,      // APB byte address
	input  wire logic [31:0]                 PWDATA,     // APB write data
	output logic      [31:0]                 PRDATA,     // APB read data
	output logic                             PREADY,     // APB ready
	output logic                             PSLVERR,    // APB error on unmapped address
	input  wire logic [fmc_pkg::NCH-1:0]     PROGRAMMABLE_IO_TERMINAL, // Input terminals
	input  wire logic                        SAMPLE_CLK  // Shared sample clock
);
	import fmc_pkg::*;

	// Synchroniser stages and edge history of the pins
	logic [NCH-1:0] pio_meta;                        // First stage, read by pio_sync only
	logic [NCH-1:0] pio_sync;                        // Second stage
	logic [NCH-1:0] pio_last;                        // Edge history
	logic [NCH-1:0] pio_rise;                        // Rising edge per terminal
	logic           sclk_meta;                       // First stage of sample clock
	logic           sclk_sync;                       // Second stage
	logic           sclk_last;                       // Edge history
	logic           sclk_rise;                       // Sample clock active edge

	// Software-visible state
	fmc_cfg_t       cfg      [NCH];                  // Per-counter configuration
	logic [31:0]    div      [NCH];                  // Per-counter divide-down count
	fmc_sample_t    head     [NCH];                  // Oldest buffered sample
	logic           nonempty [NCH];                  // Buffer holds a sample
	logic           ovf      [NCH];                  // Sticky buffer overflow
	logic [NCH-1:0] pop;                             // Read of the timebase word
	logic [NCH-1:0] ovf_clr;                         // Overflow clear strobes

	// Pair wiring between adjacent counters
	logic           gate     [NCH];                  // Gating pulse of an even counter
	logic           hold     [NCH];                  // Gate just ended, result pending
	logic [31:0]    pcnt     [NCH];                  // Partner timebase count
	logic           tb_tick  [NCH];                  // Timebase tick per counter, seen by the pair

	// APB helpers
	logic           apb_acc;                         // Access edge of a transfer
	logic [2:0]     apb_ch;                          // Addressed counter
	logic [31:0]    rd_word;                         // Read data for setup latch
	logic           rd_err;                          // Unmapped address
	logic [NCH-1:0] ne_vec;                          // Not-empty flags packed
	logic [NCH-1:0] ovf_vec;                         // Overflow flags packed

	// True when a counter word at the given offset is addressed
	function automatic logic fmc_chan_hit(input logic [ADDR_W-1:0] a, input logic [3:0] off);
		fmc_chan_hit = !a[7] && (a[3:0] == off);
	endfunction

	// Timebase tick for one counter from its source selection
	function automatic logic fmc_tick(input logic [3:0] src, input logic [NCH-1:0] rise);
		if (src == TBSRC_INT) begin
			fmc_tick = 1'b1;                         // Internal timebase ticks every clock
		end else if (src <= 4'h8) begin
			fmc_tick = rise[3'(src - 4'h1)];         // External terminal edge
		end else begin
			fmc_tick = 1'b0;                         // No source
		end
	endfunction

	// Two-stage synchronisers for pins
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			pio_meta  <= 8'h00;
			pio_sync  <= 8'h00;
			pio_last  <= 8'h00;
			sclk_meta <= 1'b0;
			sclk_sync <= 1'b0;
			sclk_last <= 1'b0;
		end else begin
			pio_meta  <= PROGRAMMABLE_IO_TERMINAL;
			pio_sync  <= pio_meta;
			pio_last  <= pio_sync;
			sclk_meta <= SAMPLE_CLK;
			sclk_sync <= sclk_meta;
			sclk_last <= sclk_sync;
		end
	end

	// Edge detection behind the second stage
	always_comb begin
		pio_rise  = pio_sync & ~pio_last;
		sclk_rise = sclk_sync & ~sclk_last;
	end

	// APB decode
	always_comb begin
		apb_acc = PSEL && PENABLE && PREADY;
		apb_ch  = PADDR[6:4];
		for (int i = 0; i < NCH; i++) begin
			ne_vec[i]  = nonempty[i];
			ovf_vec[i] = ovf[i];
			pop[i]     = apb_acc && !PWRITE && fmc_chan_hit(PADDR, OFF_TB) && (apb_ch == 3'(i));
			ovf_clr[i] = apb_acc && PWRITE && (PADDR == OFF_STATUS) && PWDATA[NCH + i];
		end
	end

	// Read multiplexer
	always_comb begin
		rd_word = 32'h0000_0000;
		rd_err  = 1'b0;
		if (PADDR == OFF_STATUS) begin
			rd_word = {16'h0000, ovf_vec, ne_vec};
		end else if (PADDR[7]) begin
			rd_err  = 1'b1;                          // Unmapped upper half
		end else begin
			case (PADDR[3:0])
				OFF_CFG: begin
					rd_word = {19'h00000, cfg[apb_ch]};
				end
				OFF_DIV: begin
					rd_word = div[apb_ch];
				end
				OFF_PER: begin
					rd_word = head[apb_ch].period_count;
				end
				OFF_TB: begin
					rd_word = head[apb_ch].timebase_cycle_count;
				end
				default: begin
					rd_err  = 1'b1;                  // Unaligned or unused word
				end
			endcase
		end
	end

	// APB answer: one wait-free access phase
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			PREADY  <= 1'b0;
			PRDATA  <= 32'h0000_0000;
			PSLVERR <= 1'b0;
		end else begin
			PREADY <= PSEL && !PENABLE;
			if (PSEL && !PENABLE) begin
				PRDATA  <= PWRITE ? 32'h0000_0000 : rd_word;
				PSLVERR <= rd_err;
			end
		end
	end

	// Configuration registers
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			for (int i = 0; i < NCH; i++) begin
				cfg[i]                        <= '0;
				cfg[i].input_terminal_select  <= 3'(i);
				cfg[i].timebase_source_select <= TBSRC_INT;
				div[i]                        <= DIV_RESET;
			end
		end else if (apb_acc && PWRITE && !rd_err) begin
			if (fmc_chan_hit(PADDR, OFF_CFG)) begin
				cfg[apb_ch] <= fmc_cfg_t'(PWDATA[CFG_W-1:0]);
			end
			if (fmc_chan_hit(PADDR, OFF_DIV)) begin
				div[apb_ch] <= PWDATA;
			end
		end
	end

	// Eight counters from one template; odd ones cannot be large range masters
	for (genvar g = 0; g < NCH; g++) begin : g_ctr
		localparam int P   = g ^ 1;                                  // Fixed partner index
		localparam bit ODD = (g % 2) == 1;                           // Odd counters are partners

		fmc_state_t       st;                                        // Sequence state
		logic [31:0]      run_cnt;                                   // Timebase since last edge
		logic [31:0]      per_acc;                                   // Periods in window
		logic [31:0]      tb_acc;                                    // Timebase over those periods
		logic [31:0]      last_per;                                  // Last full period length
		logic             last_ok;                                   // A full period was seen
		logic             done;                                      // Large range gate ended
		logic             edge_in;                                   // Input rising edge
		logic             tick;                                      // Timebase tick
		logic             occ;                                       // Used as partner counter
		logic             lg;                                        // Large range master
		logic             go;                                        // Valid and enabled
		logic             timed;                                     // Sample clock timed
		logic             fin;                                       // Full period completed
		logic             gate_end;                                  // Gate length reached
		logic [31:0]      run_inc;                                   // Running count incl. tick
		logic [31:0]      div_eff;                                   // Divider, zero read as one
		logic             push;                                      // Store a sample
		fmc_sample_t      pdata;                                     // Sample to store
		fmc_sample_t      mem [FIFO_DEPTH];                          // Sample storage
		logic [FIFO_AW:0] wp;                                        // Write pointer
		logic [FIFO_AW:0] rp;                                        // Read pointer
		logic             full;                                      // Buffer full
		logic             empty;                                     // Buffer empty

		// Mode and input selection
		always_comb begin
			edge_in  = pio_rise[cfg[g].input_terminal_select];
			tick     = fmc_tick(cfg[g].timebase_source_select, pio_rise);
			occ      = ODD && cfg[P].enable && (cfg[P].method_select == METH_LARGE);
			lg       = !ODD && (cfg[g].method_select == METH_LARGE);
			go       = cfg[g].enable && !occ && (cfg[g].method_select != 2'h3)
				&& !(ODD && (cfg[g].method_select == METH_LARGE));
			timed    = (cfg[g].method_select == METH_SAMPLE)
				|| ((cfg[g].method_select == METH_LOWFREQ) && !cfg[g].implicit_timing);
			fin      = (st == ST_RUN) && edge_in && !lg;
			run_inc  = run_cnt + {31'h0, tick};
			div_eff  = (div[g] == 32'h0) ? 32'h1 : div[g];
			if (cfg[g].time_mode) begin
				// Count the tick of this edge too, so the gate spans exactly the programmed cycles
				gate_end = (pcnt[P] + {31'h0, tb_tick[P]}) >= div_eff;
			end else begin
				gate_end = (per_acc + {31'h0, edge_in}) >= div_eff;
			end
		end

		// Sample selection per method
		always_comb begin
			push  = 1'b0;
			pdata = '0;
			if (lg) begin
				push  = done;
				pdata = {per_acc, pcnt[P]};
			end else if (timed) begin
				push = (st != ST_IDLE) && sclk_rise;
				if (cfg[g].averaging_enable && (cfg[g].method_select == METH_SAMPLE)) begin
					pdata.period_count         = per_acc + {31'h0, fin};
					pdata.timebase_cycle_count = tb_acc + (fin ? run_inc : 32'h0);
				end else begin
					pdata.period_count         = {31'h0, fin || last_ok};
					pdata.timebase_cycle_count = fin ? run_inc : (last_ok ? last_per : 32'h0);
				end
			end else begin
				push  = fin;
				pdata = {32'h1, run_inc};
			end
		end

		// Measurement sequence and counters
		always_ff @(posedge MCLK or posedge RST) begin
			if (RST) begin
				st       <= ST_IDLE;
				run_cnt  <= 32'h0;
				per_acc  <= 32'h0;
				tb_acc   <= 32'h0;
				last_per <= 32'h0;
				last_ok  <= 1'b0;
				done     <= 1'b0;
				gate[g]  <= 1'b0;
			end else begin
				case (st)
					ST_IDLE: begin
						gate[g] <= 1'b0;
						done    <= 1'b0;
						if (go) begin
							st      <= ST_ARM;
							run_cnt <= 32'h0;
							per_acc <= 32'h0;
							tb_acc  <= 32'h0;
							last_ok <= 1'b0;
						end
					end
					ST_ARM: begin
						// Partial first period is discarded
						if (!go) begin
							st <= ST_IDLE;
						end else if (edge_in) begin
							st      <= ST_RUN;
							run_cnt <= 32'h0;
							per_acc <= 32'h0;
							tb_acc  <= 32'h0;
							gate[g] <= lg;
						end
					end
					ST_RUN: begin
						if (!go) begin
							st      <= ST_IDLE;
							gate[g] <= 1'b0;
						end else if (lg) begin
							if (done) begin
								done <= 1'b0;
								st   <= ST_ARM;
							end else if (gate[g]) begin
								per_acc <= per_acc + {31'h0, edge_in};
								if (gate_end) begin
									gate[g] <= 1'b0;
									done    <= 1'b1;
								end
							end
						end else begin
							run_cnt <= edge_in ? 32'h0 : run_inc;
							if (edge_in) begin
								last_per <= run_inc;
								last_ok  <= 1'b1;
							end
							if (sclk_rise && timed) begin
								per_acc <= 32'h0;
								tb_acc  <= 32'h0;
							end else if (edge_in) begin
								per_acc <= per_acc + 32'h1;
								tb_acc  <= tb_acc + run_inc;
							end
						end
					end
					default: begin
						st <= ST_IDLE;
					end
				endcase
			end
		end

		// Pending flag and timebase tick seen by the partner
		always_comb begin
			hold[g]    = done;
			tb_tick[g] = tick;
		end

		// Partner count of timebase while the even counter gates
		always_ff @(posedge MCLK or posedge RST) begin
			if (RST) begin
				pcnt[g] <= 32'h0;
			end else if (!occ || (!gate[P] && !hold[P])) begin
				pcnt[g] <= 32'h0;
			end else if (gate[P] && tick) begin
				pcnt[g] <= pcnt[g] + 32'h1;
			end
		end

		// Buffer flags and head
		always_comb begin
			empty       = wp == rp;
			full        = (wp ^ rp) == {1'b1, {FIFO_AW{1'b0}}};
			nonempty[g] = !empty;
			head[g]     = empty ? '0 : mem[rp[FIFO_AW-1:0]];
		end

		// Buffer storage
		always_ff @(posedge MCLK) begin
			if (push && !full) begin
				mem[wp[FIFO_AW-1:0]] <= pdata;
			end
		end

		// Buffer pointers and sticky overflow, set beats clear
		always_ff @(posedge MCLK or posedge RST) begin
			if (RST) begin
				wp     <= '0;
				rp     <= '0;
				ovf[g] <= 1'b0;
			end else begin
				if (push && !full) begin
					wp <= wp + 3'h1;
				end
				if (pop[g] && !empty) begin
					rp <= rp + 3'h1;
				end
				if (push && full) begin
					ovf[g] <= 1'b1;
				end else if (ovf_clr[g]) begin
					ovf[g] <= 1'b0;
				end
			end
		end
	end
endmodule

/* test/fmc_source.sv */
// Model of the signal source and sample clock that feed the counter terminals
`timescale 1ns/10ps
module fmc_source (
	input  wire logic                    clk,  // Block clock, source steps on it
	input  wire logic                    run,  // Source active; lines rest low when idle
	output logic [fmc_pkg::NCH-1:0]      term, // Terminal i: period 10+2*i clocks
	output logic                         smp   // Sample clock: period 90 clocks
);
	import fmc_pkg::*;
	int tick; // Cycles since the source started

	// Free count while running, cleared when stopped
	always @(posedge clk) begin
		tick <= run ? tick + 1 : 0;
	end

	// Square waves derived from the count, held low when stopped
	always_comb begin
		for (int i = 0; i < NCH; i++) begin
			term[i] = run && ((tick / (5 + i)) % 2 == 1);
		end
		smp = run && ((tick / 45) % 2 == 1);
	end
endmodule

/* test/fmc_checker.sv */
// Concurrent checks on the register side of the frequency measure counter
`timescale 1ns/10ps
module fmc_checker (
	input  wire logic                        MCLK,
	input  wire logic                        RST,
	input  wire logic                        PSEL,
	input  wire logic                        PENABLE,
	input  wire logic                        PWRITE,
	input  wire logic [fmc_pkg::ADDR_W-1:0]  PADDR,
	input  wire logic [31:0]                 PWDATA,
	input  wire logic [31:0]                 PRDATA,
	input  wire logic                        PREADY,
	input  wire logic                        PSLVERR,
	input  wire logic [fmc_pkg::NCH-1:0]     PROGRAMMABLE_IO_TERMINAL,
	input  wire logic                        SAMPLE_CLK
);
	import fmc_pkg::*;
	logic [31:0] div_shadow [NCH]; // Last divide value written per counter
	logic        acc;              // Committed transfer
	logic        div_hit;          // Transfer aims at a divide word
	assign acc     = PSEL && PENABLE && PREADY;
	assign div_hit = PADDR < 8'h80 && PADDR[3:0] == OFF_DIV;
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (RST);
	sequence setup_s;
		PSEL && !PENABLE;
	endsequence
	sequence read_s;
		acc && !PWRITE;
	endsequence

	// Shadow of the divide words, updated on committed writes
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			for (int i = 0; i < NCH; i++) div_shadow[i] <= DIV_RESET;
		end else if (acc && PWRITE && div_hit) begin
			div_shadow[PADDR[6:4]] <= PWDATA;
		end
	end

	ready_after_setup_a: assert property (setup_s |=> PREADY) else $error("No ready after setup");
	ready_pulse_a: assert property (PREADY |=> !PREADY) else $error("Ready longer than one cycle");
	ready_cause_a: assert property ($rose(PREADY) |-> $past(PSEL && !PENABLE)) else $error("Ready without setup");
	mapped_ok_a: assert property (PREADY && PADDR <= 8'h80 && PADDR[1:0] == 2'h0 |-> !PSLVERR)
		else $error("Error on a mapped word");
	unmapped_err_a: assert property (PREADY && (PADDR > 8'h80 || PADDR[1:0] != 2'h0) |-> PSLVERR && PRDATA == 32'h0)
		else $error("Unmapped word not refused");
	div_back_a: assert property (read_s ##0 div_hit |-> PRDATA == div_shadow[PADDR[6:4]])
		else $error("Divide word lost");
	cfg_zero_a: assert property (read_s ##0 (PADDR < 8'h80 && PADDR[3:0] == OFF_CFG) |-> PRDATA[31:13] == 19'h0)
		else $error("Config spare bits set");
	write_zero_a: assert property (acc && PWRITE |-> PRDATA == 32'h0) else $error("Read data on a write");
	reset_quiet_a: assert property ($fell(RST) |-> !PREADY && !PSLVERR && PRDATA == 32'h0)
		else $error("Bus busy after reset");
endmodule

bind fmc_top fmc_checker chk (.MCLK(MCLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
	.PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
	.PROGRAMMABLE_IO_TERMINAL(PROGRAMMABLE_IO_TERMINAL), .SAMPLE_CLK(SAMPLE_CLK));

/* test/tb_frequency_measure_counter.sv */
// Self-checking bench for the frequency measure counter
`timescale 1ns/10ps
`define CHK(g, w) begin num_checks++; if ((g) !== (w)) begin fail_count++; $display("ERROR %0t: got %h want %h", $time, g, w); end end
module tb_frequency_measure_counter;
	import fmc_pkg::*;
	logic              MCLK    = 1'b0;   // Block clock
	logic              RST     = 1'b1;   // Reset
	logic              PSEL    = 1'b0;   // Bus select
	logic              PENABLE = 1'b0;   // Bus access phase
	logic              PWRITE  = 1'b0;   // Bus direction
	logic [7:0]        PADDR   = 8'h00;  // Bus address
	logic [31:0]       PWDATA  = 32'h0;  // Bus write data
	logic [31:0]       PRDATA;           // Bus read data
	logic              PREADY;           // Bus ready
	logic              PSLVERR;          // Bus error
	logic [NCH-1:0]    term;             // Source terminals
	logic              smp;              // Source sample clock
	logic              run     = 1'b0;   // Source running
	logic [33:0]       exp_q [$];        // Notes: check, error, data
	logic [33:0]       e;                // Note being compared
	logic [15:0]       rnd     = 16'h8481; // Random generator state
	logic [31:0]       rv;               // Random word
	int                fail_count = 0;   // Mismatches
	int                num_checks = 0;   // Comparisons

	always #25 MCLK = ~MCLK;

	fmc_top uut (.MCLK(MCLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
		.PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
		.PROGRAMMABLE_IO_TERMINAL(term), .SAMPLE_CLK(smp));
	fmc_source src (.clk(MCLK), .run(run), .term(term), .smp(smp));

	// Next random value
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	// Counts, verdict and end of run
	task automatic close_out();
		$display("Checks %0d, errors %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// One bus transfer; a read leaves its note first
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [1:0] ce);
		int n;
		n = 0;
		if (!wr) exp_q.push_back({ce, d});
		@(posedge MCLK);
		PSEL    <= 1'b1;
		PENABLE <= 1'b0;
		PWRITE  <= wr;
		PADDR   <= a;
		PWDATA  <= wr ? d : 32'h0;
		@(posedge MCLK);
		PENABLE <= 1'b1;
		// Sample ready at each rising edge; the request stands until it is seen high or 16 edges pass
		do begin
			@(posedge MCLK);
			n++;
		end while (PREADY !== 1'b1 && n < 16);
		if (PREADY !== 1'b1) begin
			fail_count++;
			$display("ERROR %0t: no ready", $time);
			close_out();
		end
		PSEL    <= 1'b0;
		PENABLE <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 2'b00);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] d);
		apb(1'b0, a, d, 2'b10);
	endtask

	// Head sample of a counter; c low skips the compare
	task automatic pair(input int n, input logic [31:0] p, input logic [31:0] t, input logic c);
		apb(1'b0, 8'(n * 16 + 8), p, {c, 1'b0});
		apb(1'b0, 8'(n * 16 + 12), t, {c, 1'b0});
	endtask

	// Take the oldest note for each read answer; compare only when its check bit is set
	always @(posedge MCLK) begin
		if (PSEL && PENABLE && PREADY === 1'b1 && !PWRITE) begin
			if (exp_q.size() == 0) begin
				fail_count++;
				$display("ERROR %0t: unexpected read", $time);
			end else begin
				e = exp_q.pop_front();
				if (e[33]) `CHK({PSLVERR, PRDATA}, e[32:0])
			end
		end
	end

	// Main sequence
	initial begin
		repeat (8) @(posedge MCLK);
		RST <= 1'b0;
		rd(OFF_STATUS, 32'h0);
		rd(8'h04, DIV_RESET);
		rd(8'h30, 32'h0000_00C0);
		apb(1'b0, 8'h90, 32'h0, 2'b11);
		apb(1'b0, 8'h02, 32'h0, 2'b11);
		for (int i = 0; i < 2; i++) begin
			rnd = lfsr(rnd);
			rv  = {rv[15:0], rnd};
		end
		wr(8'h54, rv);
		rd(8'h54, rv);
		run <= 1'b1;
		// Low frequency, implicit, terminal 5, run into overflow
		wr(8'h00, 32'h0000_0169);
		repeat (200) @(posedge MCLK);
		wr(8'h00, 32'h0);
		rd(OFF_STATUS, 32'h0000_0101);
		repeat (4) pair(0, 32'h1, 32'h14, 1'b1);
		wr(OFF_STATUS, 32'h0000_0100);
		rd(OFF_STATUS, 32'h0);
		// Same with terminal 0 as timebase
		wr(8'h00, 32'h0000_0369);
		repeat (70) @(posedge MCLK);
		wr(8'h00, 32'h0);
		pair(0, 32'h1, 32'h2, 1'b1);
		repeat (3) apb(1'b0, 8'h0C, 32'h0, 2'b00);
		// Sample clock: counter 2 single period, counter 4 averaging, counter 3 low frequency timed
		wr(8'h20, 32'h0000_00A0);
		wr(8'h40, 32'h0000_0124);
		wr(8'h30, 32'h0000_00E1);
		repeat (400) @(posedge MCLK);
		wr(8'h20, 32'h0);
		wr(8'h40, 32'h0);
		wr(8'h30, 32'h0);
		pair(2, 32'h0, 32'h0, 1'b0);
		repeat (3) pair(2, 32'h1, 32'h0E, 1'b1);
		repeat (2) pair(4, 32'h0, 32'h0, 1'b0);
		repeat (2) pair(4, 32'h5, 32'h5A, 1'b1);
		repeat (4) pair(3, 32'h1, 32'h10, 1'b1);
		// Large range on pair 6-7; odd counter asked for it stays idle
		wr(8'h64, 32'h3);
		wr(8'h60, 32'h0000_01A2);
		wr(8'h10, 32'h0000_0062);
		repeat (120) @(posedge MCLK);
		rd(OFF_STATUS, 32'h0000_0040);
		wr(8'h60, 32'h0);
		wr(8'h10, 32'h0);
		pair(6, 32'h3, 32'h42, 1'b1);
		// Large range gated by a time of 48 timebase cycles; period 22 gives two edges
		wr(8'h64, 32'h30);
		wr(8'h60, 32'h0000_01B2);
		repeat (80) @(posedge MCLK);
		wr(8'h60, 32'h0);
		pair(6, 32'h2, 32'h30, 1'b1);
		repeat (4) @(posedge MCLK);
		close_out();
	end
endmodule
